// >>> bench/adc_output_format_averaging_tb.sv
/*
  self-checking bench for output_format_averaging: register readback, reserved
  bit masking, coding, gain and averaging against a queue model.
  assumes the hand-over timing: readback one cycle late, results as pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module adc_output_format_averaging_tb;
  logic clk, rst_n, reg_wr, sample_valid, result_valid, gce;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, gain_factor, sample_data, result_data, cfg, e;
  logic [3:0] lane_select;
  logic [31:0] rnd = 32'h2bb9;
  logic [15:0] expq[$];
  int error_cnt = 0, n_compared = 0, acc = 0, cnt = 0;
  output_format_averaging #(.width(16)) i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .gain_factor(gain_factor), .sample_valid(sample_valid), .sample_data(sample_data),
    .result_valid(result_valid), .result_data(result_data),
    .gain_cal_global_enable(gce), .lane_select(lane_select));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // gain is kept below unity in the bench so the product never wraps
  function automatic logic [15:0] fmt(input logic [15:0] x);
    logic [31:0] p;
    logic [15:0] v;
    v = x;
    if (cfg[7]) begin
      p = v * gain_factor;
      v = p[30:15];
    end
    if (cfg[13]) v[15] = ~v[15];
    return v;
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 8'h0d) cfg = (d & 16'h20f0) | (16'h2002 & ~16'h20f0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    `CHK(reg_rdata, x)
  endtask
  task automatic send(input logic [15:0] d);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_data <= d;
    if (cfg[6]) begin
      acc += d;
      cnt++;
      if (cnt == (2 << cfg[5:4])) begin
        expq.push_back(fmt(16'(acc / (2 << cfg[5:4]))));
        acc = 0;
        cnt = 0;
      end
    end else expq.push_back(fmt(d));
  endtask
  task automatic stream(input int n);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      send(rnd[15:0]);
    end
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rst_n && result_valid === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        e = expq.pop_front();
        `CHK(result_data, e)
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
    sample_valid = 1'b0; sample_data = 16'h0000; gain_factor = 16'h8000; cfg = 16'h2002;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'h00, 16'h0002);
    rd(8'h0d, 16'h2002);
    rd(8'h12, 16'h0002);
    rd(8'h33, 16'h0000);
    stream(6);
    wr(8'h0d, 16'hffff);
    rd(8'h0d, 16'h20f2);
    wr(8'h12, 16'hffff);
    rd(8'h12, 16'h000f);
    `CHK(lane_select, 4'hf)
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      gain_factor <= {1'b0, rnd[14:0]};
      wr(8'h0d, {2'h0, m[0], 5'h00, m[1], 7'h02});
      #1;
      `CHK(gce, cfg[7])
      stream(8);
    end
    for (int d = 0; d < 4; d++) begin
      wr(8'h0d, 16'(16'h2042 | (d << 4) | (d[0] << 7)));
      rd(8'h0d, cfg);
      stream((2 << d) * 2 + 1);
      wr(8'h0d, 16'h2002);
      acc = 0;
      cnt = 0;
    end
    `CHK(32'(expq.size()), 32'd0)
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> rtl/fmt_avg_pkg.sv
/*
  constants for the output formatting and averaging block: register offsets,
  field positions, reset values and codes.
  assumes a 16-bit register word reached by an 8-bit register address.
*/
package fmt_avg_pkg;
  localparam logic [7:0] proc_cfg_offset = 8'h0d;
  localparam logic [7:0] lane_cfg_offset = 8'h12;
  localparam logic [15:0] proc_cfg_reset = 16'h2002;
  localparam logic [15:0] lane_cfg_reset = 16'h0002;
  localparam int coding_bit = 13;
  localparam int gain_cal_bit = 7;
  localparam int avg_en_bit = 6;
  localparam int depth_lsb = 4;
  localparam int depth_msb = 5;
  localparam logic [15:0] proc_cfg_writable = 16'h20f0;
  localparam logic [15:0] lane_cfg_writable = 16'h000f;
  localparam logic coding_offset_binary = 1'b0;
  localparam logic coding_twos = 1'b1;
endpackage

// >>> rtl/output_format_averaging.sv
/*
  output processing for one converter channel: register port for the
  processing and lane configuration words, averaging, gain correction and
  output coding.
  assumes raw results are offset binary and the gain factor comes from the
  calibration logic outside.
*/
`timescale 1ns/1ns
`default_nettype none
module output_format_averaging #(
  parameter int width = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] gain_factor,
  input wire logic sample_valid,
  input wire logic [width-1:0] sample_data,
  output logic result_valid,
  output logic [width-1:0] result_data,
  output logic gain_cal_global_enable,
  output logic [3:0] lane_select
);
  logic [15:0] proc_reg, proc_next;
  logic [15:0] lane_reg, lane_next;
  logic [15:0] rdata_reg, rdata_next;
  logic vld_reg, vld_next;
  logic [width-1:0] dat_reg, dat_next;
  logic averaging_enable;
  logic [1:0] averaging_depth;
  logic avg_valid;
  logic [width-1:0] avg_data;
  logic mid_valid;
  logic [width-1:0] mid_data;
  logic [width+15:0] prod;

  // reserved bits are held at their reset value so readback stays defined
  // even if software ignores the write-back convention
  function automatic logic [15:0] merge(input logic [15:0] rst_val,
      input logic [15:0] mask, input logic [15:0] wd);
    merge = (wd & mask) | (rst_val & ~mask);
  endfunction

  // one decode shared by the write and the readback paths
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  always_comb begin
    proc_next = proc_reg;
    lane_next = lane_reg;
    if (reg_wr && addr_hit(reg_addr, fmt_avg_pkg::proc_cfg_offset)) begin
      proc_next = merge(fmt_avg_pkg::proc_cfg_reset, fmt_avg_pkg::proc_cfg_writable,
        reg_wdata);
    end
    if (reg_wr && addr_hit(reg_addr, fmt_avg_pkg::lane_cfg_offset)) begin
      lane_next = merge(fmt_avg_pkg::lane_cfg_reset, fmt_avg_pkg::lane_cfg_writable,
        reg_wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      proc_reg <= fmt_avg_pkg::proc_cfg_reset;
      lane_reg <= fmt_avg_pkg::lane_cfg_reset;
    end else begin
      proc_reg <= proc_next;
      lane_reg <= lane_next;
    end
  end

  // readback shows the register as it stood before a write in the same cycle
  always_comb begin
    rdata_next = 16'h0000;
    if (addr_hit(reg_addr, fmt_avg_pkg::proc_cfg_offset)) begin
      rdata_next = proc_reg;
    end else if (addr_hit(reg_addr, fmt_avg_pkg::lane_cfg_offset)) begin
      rdata_next = lane_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign averaging_enable = proc_reg[fmt_avg_pkg::avg_en_bit];
  assign averaging_depth = proc_reg[fmt_avg_pkg::depth_msb:fmt_avg_pkg::depth_lsb];
  assign gain_cal_global_enable = proc_reg[fmt_avg_pkg::gain_cal_bit];
  assign lane_select = lane_reg[3:0];

  sample_averager #(.width(width)) u_avg (
    .clk(clk),
    .rst_n(rst_n),
    .enable(averaging_enable),
    .depth(averaging_depth),
    .in_valid(sample_valid),
    .in_data(sample_data),
    .out_valid(avg_valid),
    .out_data(avg_data)
  );

  // bypass path skips the averager latency entirely
  assign mid_valid = averaging_enable ? avg_valid : sample_valid;
  assign mid_data = averaging_enable ? avg_data : sample_data;

  always_comb begin
    // gain factor is unsigned with 15 fraction bits, 8000h is unity
    prod = (width+16)'(mid_data) * (width+16)'(gain_factor);
    vld_next = mid_valid;
    dat_next = dat_reg;
    if (mid_valid) begin
      dat_next = gain_cal_global_enable ? width'(prod >> 15) : mid_data;
      if (proc_reg[fmt_avg_pkg::coding_bit] == fmt_avg_pkg::coding_twos) begin
        dat_next[width-1] = ~dat_next[width-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vld_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      vld_reg <= vld_next;
      dat_reg <= dat_next;
    end
  end

  assign result_valid = vld_reg;
  assign result_data = dat_reg;

  bypass_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!averaging_enable && sample_valid) |=> result_valid)
    else $error("bypassed sample did not appear one cycle later");
  coding_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mid_valid && !gain_cal_global_enable && proc_reg[fmt_avg_pkg::coding_bit]) |=>
    (result_data[width-1] == ~$past(mid_data[width-1])))
    else $error("two's complement coding not applied");
  reserved_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((proc_reg & ~fmt_avg_pkg::proc_cfg_writable) ==
     (fmt_avg_pkg::proc_cfg_reset & ~fmt_avg_pkg::proc_cfg_writable)))
    else $error("reserved processing bits changed");
  reset_value_a: assert property (@(posedge clk) $rose(rst_n) |->
    (proc_reg == fmt_avg_pkg::proc_cfg_reset && lane_reg == fmt_avg_pkg::lane_cfg_reset))
    else $error("register reset value wrong");

  proc_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == fmt_avg_pkg::proc_cfg_offset) |=>
    ((proc_reg & fmt_avg_pkg::proc_cfg_writable) ==
     ($past(reg_wdata) & fmt_avg_pkg::proc_cfg_writable)))
    else $error("processing register write not taken");

  lane_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == fmt_avg_pkg::lane_cfg_offset) |=>
    ((lane_reg & fmt_avg_pkg::lane_cfg_writable) ==
     ($past(reg_wdata) & fmt_avg_pkg::lane_cfg_writable)))
    else $error("lane register write not taken");

  lane_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((lane_reg & ~fmt_avg_pkg::lane_cfg_writable) ==
     (fmt_avg_pkg::lane_cfg_reset & ~fmt_avg_pkg::lane_cfg_writable)))
    else $error("reserved lane bits changed");

  write_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(reg_wr && (reg_addr == fmt_avg_pkg::proc_cfg_offset ||
      reg_addr == fmt_avg_pkg::lane_cfg_offset)) |=>
    ($stable(proc_reg) && $stable(lane_reg)))
    else $error("register changed without a write");

  read_proc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_addr == fmt_avg_pkg::proc_cfg_offset) |=> (reg_rdata == $past(proc_reg)))
    else $error("processing register readback wrong");

  read_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_addr == fmt_avg_pkg::lane_cfg_offset) |=> (reg_rdata == $past(lane_reg)))
    else $error("lane register readback wrong");

  read_unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_addr != fmt_avg_pkg::proc_cfg_offset && reg_addr != fmt_avg_pkg::lane_cfg_offset)
    |=> (reg_rdata == 16'h0000))
    else $error("unmapped readback not zero");

  straight_binary_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mid_valid && !gain_cal_global_enable && !proc_reg[fmt_avg_pkg::coding_bit]) |=>
    (result_data == $past(mid_data)))
    else $error("offset binary result altered");

  gain_scale_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mid_valid && gain_cal_global_enable && !proc_reg[fmt_avg_pkg::coding_bit]) |=>
    (result_data == $past(prod[width+14:15])))
    else $error("gain correction not applied");

  averaged_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (averaging_enable && !avg_valid) |=> !result_valid)
    else $error("result left between averaged words");

  bypass_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!averaging_enable && !sample_valid) |=> !result_valid)
    else $error("bypass result without a sample");

  result_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !mid_valid |=> $stable(result_data))
    else $error("result data changed without a sample");
endmodule
`default_nettype wire

// >>> rtl/sample_averager.sv
/*
  averages 2, 4, 8 or 16 consecutive samples of one channel and emits one
  word per group.
  assumes samples arrive as a one-cycle valid on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module sample_averager #(
  parameter int width = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] depth,
  input wire logic in_valid,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  output logic [width-1:0] out_data
);
  logic [width+3:0] acc_reg, acc_next;
  logic [3:0] cnt_reg, cnt_next;
  logic out_valid_reg, out_valid_next;
  logic [width-1:0] out_data_reg, out_data_next;
  logic [3:0] last;
  logic [width+3:0] sum;

  always_comb begin
    last = 4'((5'h02 << depth) - 5'h01);
    sum = acc_reg + (width+4)'(in_data);
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    out_valid_next = 1'b0;
    out_data_next = out_data_reg;
    if (!enable) begin
      acc_next = '0;
      cnt_next = 4'h0;
    end else if (in_valid) begin
      if (cnt_reg >= last) begin
        // one word per group; the shift divides by the group size
        out_valid_next = 1'b1;
        // shift amount needs three bits: depth 3 divides by 16
        out_data_next = width'(sum >> ({1'b0, depth} + 3'h1));
        acc_next = '0;
        cnt_next = 4'h0;
      end else begin
        acc_next = sum;
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_reg <= '0;
      cnt_reg <= 4'h0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  group_size_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && depth == 2'h0 && in_valid && cnt_reg == 4'h1) |=> out_valid)
    else $error("averager did not emit after two samples");
endmodule
`default_nettype wire
